// file: common/tsi_regs.vh
// Constants shared by the temperature sensor bus target port.
`ifndef TSI_REGS_VH
`define TSI_REGS_VH
`define TSI_ADDR_LOW        7'h4A
`define TSI_ADDR_HIGH       7'h4B
`define TSI_CLK_MHZ         100
`define TSI_PU_TYP_US       500
`define TSI_PU_MAX_US       1000
`define TSI_PU_CYCLES       ((`TSI_PU_TYP_US) * (`TSI_CLK_MHZ))
`define TSI_RST_MIN_NS      1000
`define TSI_RST_MIN_CYCLES  (((`TSI_RST_MIN_NS) * (`TSI_CLK_MHZ) + 999) / 1000)
`define TSI_CRC_POLY        8'h31
`define TSI_CRC_INIT        8'hFF
`define TSI_CMD_STRETCH_ON  16'h2C02
`define TSI_CMD_STRETCH_OFF 16'h2400
`define TSI_CMD_CHK_POS     0
`define TSI_CMD_CHK_W       3
`endif

// file: rtl/tsi_crc8.v
// Byte-serial checksum step used for data words on the bus.
`timescale 1ns/10ps
`include "tsi_regs.vh"
module tsi_crc8 (
   // Current checksum and next byte
   input  wire [7:0] crc_in,
   input  wire [7:0] data,
   // Updated checksum
   output wire [7:0] crc_out
);
   function [7:0] step;
      input [7:0] c;
      input [7:0] d;
      integer     i;
      reg   [7:0] r;
      begin
         r = c ^ d;
         for (i = 0; i < 8; i = i + 1) begin
            r = r[7] ? ((r << 1) ^ `TSI_CRC_POLY) : (r << 1);
         end
         step = r;
      end
   endfunction
   assign crc_out = step(crc_in, data);
endmodule

// file: rtl/tsi_target.v
// Bus target port of the temperature sensor: addressing, checksums, stretching, alert.
// Notes on behaviour
// - Answer address 0x4A with select pin low, 0x4B with it high.
// - First byte after START holds address in top seven bits, direction in bit zero.
// - Work at any bus clock up to 1000 kHz, fast-mode rules up to 400 kHz.
// - Clock stretching supported, enabled or disabled by user command.
// - Only pull data and clock low; pull-ups make the high level.
// - Drive alert high while the reading lies outside programmed limits.
// - Commands are 16-bit words carrying a 3-bit checksum inside.
// - Every data word travels with a trailing 8-bit checksum byte.
// - Written data is accepted only with a correct trailing checksum.
// - After power-on threshold a power-up delay passes before commands are accepted.
// - Idle entered automatically when neither measuring nor communicating.
// - Idle reached at most 1 ms after power-on threshold, typically 0.5 ms.
`timescale 1ns/10ps
`include "tsi_regs.vh"
module tsi_target #(
   parameter PU_CYCLES  = `TSI_PU_CYCLES,
   parameter RST_CYCLES = `TSI_RST_MIN_CYCLES
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   input  wire        external_reset_low_input,
   // Bus pins, open drain
   input  wire        scl_in,
   output reg         scl_out,
   output reg         scl_oe,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   input  wire        addr_sel,
   // Sensor core side
   input  wire [15:0] temp_value,
   input  wire        meas_busy,
   input  wire        data_ready,
   input  wire [15:0] limit_high,
   input  wire [15:0] limit_low,
   // Results to the sensor core
   output reg  [15:0] cmd_word,
   output reg         cmd_valid,
   output reg  [15:0] wdata_word,
   output reg         wdata_valid,
   output reg         wdata_crc_err,
   output reg         stretch_en,
   output reg         alert,
   output reg         idle
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ACK  = 3'd2;
   localparam ST_RX   = 3'd3;
   localparam ST_TX   = 3'd4;
   localparam ST_TACK = 3'd5;
   localparam ST_SKIP = 3'd6;

   reg  [1:0]  rst_sync;
   wire        rst_i = rst_sync[1];
   reg  [1:0]  scl_s;
   reg  [1:0]  sda_s;
   reg  [1:0]  adr_s;
   reg  [1:0]  ext_s;
   reg         scl_q;
   reg         sda_q;
   reg  [15:0] ext_cnt;
   reg         soft_rst;
   reg  [19:0] pu_cnt;
   reg         ready;
   reg  [2:0]  state;
   reg  [2:0]  bit_cnt;
   reg  [7:0]  shreg;
   reg  [2:0]  byte_idx;
   reg         rd;
   reg  [7:0]  crc;
   reg  [47:0] rx_buf;
   reg         in_txn;
   reg         adr_lat;
   reg         byte_full;
   wire [7:0]  crc_next;

   wire scl_rise = scl_s[1] & ~scl_q;
   wire scl_fall = ~scl_s[1] & scl_q;
   wire start_c  = scl_s[1] & scl_q & sda_q & ~sda_s[1];
   wire stop_c   = scl_s[1] & scl_q & ~sda_q & sda_s[1];
   wire [7:0] rx_byte = {shreg[6:0], sda_s[1]};

   tsi_crc8 u_crc (
      .crc_in  (crc),
      .data    (shreg),
      .crc_out (crc_next)
   );

   // Checks the 3-bit checksum carried in the low bits of a command word.
   function cmd_ok;
      input [15:0] w;
      begin
         cmd_ok = (w[`TSI_CMD_CHK_W-1:0] == (w[15:13] ^ w[12:10] ^ w[9:7] ^ w[6:4] ^
                   {w[3], 2'b00}));
      end
   endfunction

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // Pins are asynchronous to clk, so each passes two flip-flops first.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s <= 2'b11;
         sda_s <= 2'b11;
         adr_s <= 2'b00;
         ext_s <= 2'b11;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], scl_in};
         sda_s <= {sda_s[0], sda_in};
         adr_s <= {adr_s[0], addr_sel};
         ext_s <= {ext_s[0], external_reset_low_input};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
      end
   end

   // Short glitches are ignored; only a held low level resets the port.
   always @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         ext_cnt  <= 16'h0000;
         soft_rst <= 1'b0;
      end else if (ext_s[1]) begin
         ext_cnt  <= 16'h0000;
         soft_rst <= 1'b0;
      end else if (ext_cnt >= RST_CYCLES[15:0] - 16'h0001) begin
         soft_rst <= 1'b1;
      end else begin
         ext_cnt <= ext_cnt + 16'h0001;
      end
   end

   // Power-up delay before the port accepts any command.
   always @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         pu_cnt <= 20'h0_0000;
         ready  <= 1'b0;
      end else if (soft_rst) begin
         pu_cnt <= 20'h0_0000;
         ready  <= 1'b0;
      end else if (!ready) begin
         pu_cnt <= pu_cnt + 20'h0_0001;
         if (pu_cnt >= PU_CYCLES[19:0] - 20'h0_0001) begin
            ready <= 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         alert <= 1'b0;
         idle  <= 1'b0;
      end else begin
         alert <= ready & ((temp_value > limit_high) | (temp_value < limit_low));
         idle  <= ready & ~meas_busy & ~in_txn;
      end
   end

   // The clock line is only ever pulled low, never driven high.
   always @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         scl_oe  <= stretch_en & in_txn & rd & (byte_idx == 3'd1) & (state == ST_ACK) &
                    meas_busy & ~data_ready & ~soft_rst;
      end
   end

   always @(posedge clk or negedge rst_i) begin
      if (!rst_i) begin
         state         <= ST_IDLE;
         bit_cnt       <= 3'd0;
         shreg         <= 8'h00;
         byte_idx      <= 3'd0;
         rd            <= 1'b0;
         crc           <= `TSI_CRC_INIT;
         rx_buf        <= 48'h0000_0000_0000;
         in_txn        <= 1'b0;
         adr_lat       <= 1'b0;
         byte_full     <= 1'b0;
         sda_out       <= 1'b0;
         sda_oe        <= 1'b0;
         cmd_word      <= 16'h0000;
         cmd_valid     <= 1'b0;
         wdata_word    <= 16'h0000;
         wdata_valid   <= 1'b0;
         wdata_crc_err <= 1'b0;
         stretch_en    <= 1'b0;
      end else begin
         cmd_valid     <= 1'b0;
         wdata_valid   <= 1'b0;
         wdata_crc_err <= 1'b0;
         sda_out       <= 1'b0;
         if (soft_rst || !ready) begin
            // A reset pulse also returns clock stretching to its off default.
            state      <= ST_IDLE;
            in_txn     <= 1'b0;
            sda_oe     <= 1'b0;
            stretch_en <= 1'b0;
         end else if (start_c) begin
            state    <= ST_ADDR;
            bit_cnt  <= 3'd0;
            byte_idx <= 3'd0;
            crc      <= `TSI_CRC_INIT;
            in_txn   <= 1'b1;
            byte_full <= 1'b0;
            adr_lat  <= adr_s[1];
            sda_oe   <= 1'b0;
         end else if (stop_c) begin
            if (!rd && byte_idx == 3'd6) begin
               wdata_word <= rx_buf[23:8];
               if (rx_buf[7:0] == crc) begin
                  wdata_valid <= 1'b1;
               end else begin
                  wdata_crc_err <= 1'b1;
               end
            end
            state  <= ST_IDLE;
            in_txn <= 1'b0;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shreg     <= rx_byte;
                     bit_cnt   <= bit_cnt + 3'd1;
                     byte_full <= (bit_cnt == 3'd7);
                  end
                  // The fall that follows START must not be taken as the end of a byte.
                  if (scl_fall && byte_full && byte_idx != 3'd7) begin
                     byte_full <= 1'b0;
                     if (state == ST_ADDR) begin
                        if (shreg[7:1] == (adr_lat ? `TSI_ADDR_HIGH : `TSI_ADDR_LOW)) begin
                           rd     <= shreg[0];
                           sda_oe <= 1'b1;
                           state  <= ST_ACK;
                        end else begin
                           state <= ST_SKIP;
                        end
                     end else begin
                        rx_buf <= {rx_buf[39:0], shreg};
                        if (byte_idx == 3'd3 || byte_idx == 3'd4) begin
                           crc <= crc_next;
                        end
                        if (byte_idx == 3'd2) begin
                           cmd_word <= {rx_buf[7:0], shreg};
                           if (cmd_ok({rx_buf[7:0], shreg})) begin
                              cmd_valid <= 1'b1;
                              if ({rx_buf[7:0], shreg} == `TSI_CMD_STRETCH_ON) begin
                                 stretch_en <= 1'b1;
                              end else if ({rx_buf[7:0], shreg} == `TSI_CMD_STRETCH_OFF) begin
                                 stretch_en <= 1'b0;
                              end
                           end
                        end
                        sda_oe <= 1'b1;
                        state  <= ST_ACK;
                     end
                     byte_idx <= byte_idx + 3'd1;
                  end
               end
               ST_ACK: begin
                  if (scl_fall && !scl_oe) begin
                     if (rd) begin
                        shreg   <= (byte_idx == 3'd1) ? temp_value[15:8] :
                                   (byte_idx == 3'd2) ? temp_value[7:0] : crc;
                        state   <= ST_TX;
                        bit_cnt <= 3'd0;
                        sda_oe  <= ~((byte_idx == 3'd1) ? temp_value[15] :
                                   (byte_idx == 3'd2) ? temp_value[7] : crc[7]);
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd7) begin
                        sda_oe <= 1'b0;
                        crc    <= crc_next;
                        state  <= ST_TACK;
                     end else begin
                        sda_oe <= ~shreg[3'd6 - bit_cnt];
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     // A NACK, even before the checksum byte, simply ends the read.
                     if (sda_s[1]) begin
                        state <= ST_SKIP;
                     end else begin
                        byte_idx <= byte_idx + 3'd1;
                        state    <= ST_ACK;
                     end
                  end
               end
               ST_SKIP: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// file: tb/tsi_target_sva.sv
// Concurrent checks on the ports of the bus target port.
`timescale 1ns/10ps
module tsi_target_sva #(
   parameter int PU_CYCLES = 200
) (
   // Clock and resets
   input wire        clk,
   input wire        rst_n,
   input wire        external_reset_low_input,
   // Bus pin drivers
   input wire        scl_out,
   input wire        scl_oe,
   input wire        sda_out,
   input wire        sda_oe,
   // Core side
   input wire [15:0] temp_value,
   input wire        meas_busy,
   input wire        data_ready,
   input wire [15:0] limit_high,
   input wire [15:0] limit_low,
   input wire        cmd_valid,
   input wire        wdata_valid,
   input wire        wdata_crc_err,
   input wire        stretch_en,
   input wire        alert,
   input wire        idle
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   int up;
   // Saturates so that long runs never wrap back below the power-up figure.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) up <= 0;
      else if (up < PU_CYCLES) up <= up + 1;
   end
   sequence s_ext_low;
      !external_reset_low_input [*8];
   endsequence
   sequence s_above;
      (data_ready && temp_value > limit_high) [*4];
   endsequence
   sequence s_inside;
      (data_ready && temp_value <= limit_high && temp_value >= limit_low) [*4];
   endsequence
   a_sda_low_only: assert property (sda_oe |-> !sda_out)
      else $error("sda driven high");
   a_scl_low_only: assert property (scl_oe |-> !scl_out)
      else $error("scl driven high");
   a_stretch_gated: assert property (scl_oe |-> stretch_en)
      else $error("clock held while stretching is off");
   a_alert_above: assert property (s_above |-> alert)
      else $error("alert missing above limit");
   a_alert_below: assert property ((data_ready && temp_value < limit_low) [*4] |-> alert)
      else $error("alert missing below limit");
   a_alert_inside: assert property (s_inside |-> !alert)
      else $error("alert inside limits");
   a_idle_busy: assert property (meas_busy [*2] |-> !idle)
      else $error("idle while measuring");
   a_idle_late: assert property (idle |-> up >= PU_CYCLES)
      else $error("idle before power-up delay");
   a_ack_early: assert property (sda_oe |-> up >= PU_CYCLES)
      else $error("bus answered before power-up delay");
   a_crc_refuse: assert property (wdata_crc_err |-> !wdata_valid)
      else $error("bad data accepted");
   a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("command strobe too long");
   a_ext_reset: assert property (s_ext_low |-> ##2 (!stretch_en && !sda_oe))
      else $error("external reset ignored");
endmodule

bind tsi_target tsi_target_sva #(.PU_CYCLES(PU_CYCLES)) u_sva (
   .clk, .rst_n, .external_reset_low_input, .scl_out, .scl_oe, .sda_out, .sda_oe,
   .temp_value, .meas_busy, .data_ready, .limit_high, .limit_low, .cmd_valid,
   .wdata_valid, .wdata_crc_err, .stretch_en, .alert, .idle
);

// file: tb/tsi_i2c_master.sv
// Behavioural bus master that pulls the open-drain lines of the port.
`timescale 1ns/10ps
module tsi_i2c_master (
   // Resolved lines
   input  wire scl,
   input  wire sda,
   // Pull-down enables and hang flag
   output reg  scl_oe,
   output reg  sda_oe,
   output reg  hung
);
   // Quarter period in ns; four of them make a 1000 kHz bit.
   localparam int Q = 250;
   int w;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      hung = 1'b0;
   end
   // A target may hold the clock low, so wait until the line really rises.
   task automatic scl_hi();
      scl_oe = 1'b0;
      for (w = 0; w < 20000 && scl !== 1'b1; w++) #10;
      if (w == 20000) hung = 1'b1;
      #Q;
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_oe = !b;
      #Q;
      scl_hi();
      r = sda;
      #Q;
      scl_oe = 1'b1;
      #Q;
   endtask
   task automatic start();
      sda_oe = 1'b0;
      scl_hi();
      sda_oe = 1'b1;
      #Q;
      scl_oe = 1'b1;
      #Q;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #Q;
      scl_hi();
      sda_oe = 1'b0;
      #Q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule

// file: tb/tsi_target_tb_top.sv
// Self-checking bench for the bus target port.
`timescale 1ns/10ps
`include "tsi_regs.vh"
module tsi_target_tb_top;
   localparam int PU = 2000;
   typedef struct packed {logic s; logic [6:0] a; logic rw; logic ack;} tsi_row_t;
   tsi_row_t    rows [6] = '{'{1'b0, 7'h4A, 1'b0, 1'b1}, '{1'b0, 7'h4B, 1'b0, 1'b0},
      '{1'b1, 7'h4B, 1'b0, 1'b1}, '{1'b1, 7'h4A, 1'b1, 1'b0},
      '{1'b0, 7'h4A, 1'b1, 1'b1}, '{1'b0, 7'h25, 1'b0, 1'b0}};
   logic        clk, rst_n, external_reset_low_input, addr_sel, meas_busy, data_ready, ack;
   logic [15:0] temp_value, limit_high, limit_low, last_cmd;
   logic [7:0]  d;
   int          err_total, n_compared, n_wv, n_we, held, cyc;
   wire         scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe, hung;
   wire         cmd_valid, wdata_valid, wdata_crc_err, stretch_en, alert, idle;
   wire [15:0]  cmd_word, wdata_word;
   wire         scl = !(scl_oe & !scl_out | m_scl_oe);
   wire         sda = !(sda_oe & !sda_out | m_sda_oe);
   tsi_target #(.PU_CYCLES(PU), .RST_CYCLES(4)) dut (
      .clk, .rst_n, .external_reset_low_input, .scl_in(scl), .scl_out, .scl_oe,
      .sda_in(sda), .sda_out, .sda_oe, .addr_sel, .temp_value, .meas_busy, .data_ready,
      .limit_high, .limit_low, .cmd_word, .cmd_valid, .wdata_word, .wdata_valid,
      .wdata_crc_err, .stretch_en, .alert, .idle
   );
   tsi_i2c_master m (.scl, .sda, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .hung);
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) last_cmd <= cmd_word;
      n_wv <= n_wv + (wdata_valid === 1'b1);
      n_we <= n_we + (wdata_crc_err === 1'b1);
      held <= held + (scl_oe === 1'b1);
      cyc <= cyc + 1;
   end
   always @(posedge hung) begin
      err_total++;
      conclude();
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] crc(input logic [15:0] v);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction
   // Command, then optionally a data word with its checksum, then STOP.
   task automatic wr(input logic [15:0] c, input logic nd, input logic [23:0] dk);
      m.start();
      m.wbyte({7'h4A, 1'b0}, ack);
      m.wbyte(c[15:8], ack);
      m.wbyte(c[7:0], ack);
      if (nd) for (int i = 2; i >= 0; i--) m.wbyte(dk[i*8+:8], ack);
      m.stop();
   endtask
   task automatic al(input logic [15:0] t, input logic e);
      @(posedge clk);
      #1 temp_value = t;
      repeat (6) @(posedge clk);
      #1 chk("alert", 16'(e), 16'(alert));
   endtask
   initial begin
      {rst_n, addr_sel, meas_busy, data_ready} = 4'h0;
      external_reset_low_input = 1'b1;
      {temp_value, limit_high, limit_low} = {16'h0100, 16'h0200, 16'h0080};
      {err_total, n_compared, n_wv, n_we, held, cyc} = '0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      cyc = 0;
      m.start();
      m.wbyte({7'h4A, 1'b0}, ack);
      m.stop();
      chk("early ack", 16'h0000, 16'(ack));
      while (cyc < PU + 8) @(posedge clk);
      #1 chk("idle", 16'h0001, 16'(idle));
      foreach (rows[i]) begin
         addr_sel = rows[i].s;
         m.start();
         m.wbyte({rows[i].a, rows[i].rw}, ack);
         chk("ack", 16'(rows[i].ack), 16'(ack));
         if (ack && rows[i].rw) m.rbyte(1'b1, d);
         m.stop();
      end
      wr(`TSI_CMD_STRETCH_ON, 1'b0, 24'h0000);
      chk("cmd", `TSI_CMD_STRETCH_ON, last_cmd);
      chk("stretch on", 16'h0001, 16'(stretch_en));
      wr(16'h2400, 1'b1, {16'hBEEF, crc(16'hBEEF)});
      chk("stretch off", 16'h0000, 16'(stretch_en));
      chk("wdata", 16'hBEEF, wdata_word);
      wr(16'h2400, 1'b1, {16'h1234, crc(16'h1234) ^ 8'h01});
      chk("accepted", 16'h0001, 16'(n_wv));
      chk("refused", 16'h0001, 16'(n_we));
      wr(`TSI_CMD_STRETCH_ON, 1'b0, 24'h0000);
      meas_busy = 1'b1;
      fork
         begin
            m.start();
            m.wbyte({7'h4A, 1'b1}, ack);
            m.rbyte(1'b1, d);
            m.stop();
         end
         begin
            repeat (1500) @(posedge clk);
            #1 {meas_busy, data_ready} = 2'b01;
         end
      join
      chk("stretched", 16'h0001, 16'(held > 100));
      chk("stretched msb", 16'h0001, 16'(d));
      m.start();
      m.wbyte({7'h4A, 1'b1}, ack);
      m.rbyte(1'b0, d);
      chk("read msb", 16'h0001, 16'(d));
      m.rbyte(1'b0, d);
      chk("read lsb", 16'h0000, 16'(d));
      m.rbyte(1'b1, d);
      chk("read crc", 16'(crc(16'h0100)), 16'(d));
      m.stop();
      al(16'h0300, 1'b1);
      al(16'h0100, 1'b0);
      al(16'h0040, 1'b1);
      al(16'h0150, 1'b0);
      external_reset_low_input = 1'b0;
      repeat (10) @(posedge clk);
      #1 external_reset_low_input = 1'b1;
      repeat (5) @(posedge clk);
      chk("ext reset", 16'h0000, 16'(stretch_en));
      conclude();
   end
endmodule
